// ==== common/pbr_pkg.sv ====
// constants for the 10BASE-T control and self-test register bank
// Function
// RULE_01: bit 13 lowers receive threshold
// RULE_02: squelch code 0..8 gives 200..600 mV
// RULE_03: bit 7 set stops link pulses
// RULE_04: bit 4 mirrors inverted polarity status
// RULE_05: control read clears polarity, status read not
// RULE_06: bit 0 disables jabber, 10BASE-Te only
// RULE_07: bits 15-8 count PRBS errored bytes
// RULE_08: write one bit 15 captures, clears counter
// RULE_09: mode zero saturates counter at FF
// RULE_10: packet gap equals four times field
// RULE_11: gap field resets to 7D
// RULE_12: reserved bits read zero, writes ignored
package pbr_pkg;
  // register indexes and byte addresses
  localparam logic [7:0] IDX_CTRL = 8'h1A;
  localparam logic [7:0] IDX_TEST = 8'h1B;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h20;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h21;
  localparam logic [9:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [9:0] ADDR_TEST = {IDX_TEST, 2'b00};
  localparam logic [9:0] ADDR_IRQ_STAT = {IDX_IRQ_STAT, 2'b00};
  localparam logic [9:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};
  // control register fields
  localparam int BIT_LOW_THR = 13;
  localparam int BIT_SQ_LO = 9;
  localparam int BIT_LINK_SUPP = 7;
  localparam int BIT_POL = 4;
  localparam int BIT_JAB_DIS = 0;
  localparam int BIT_STAT_POL = 12;
  localparam logic [15:0] CTRL_WMASK = 16'h3E81;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // self-test register fields
  localparam int BIT_CAPTURE = 15;
  localparam int BIT_CNT_LO = 8;
  localparam logic [7:0] GAP_RESET = 8'h7D;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam int GAP_SHIFT = 2;
  // squelch thresholds in mV
  localparam logic [9:0] SQ_BASE_MV = 10'h0C8;
  localparam logic [9:0] SQ_STEP_MV = 10'h032;
  localparam logic [3:0] SQ_MAX_CODE = 4'h8;
  // interrupt status bits
  localparam int IRQ_POL = 0;
  localparam int IRQ_SAT = 1;
  localparam int IRQ_W = 2;
endpackage

// ==== verilog/pbr_regs.sv ====
// 10BASE-T control and self-test register bank behind classic Wishbone
`timescale 1ns/100ps
module pbr_regs (
  input wire logic clock, // 250 MHz clock
  input wire logic rst_n, // sync reset, active low
  input wire logic wbCyc, // wishbone cycle
  input wire logic wbStb, // wishbone strobe
  input wire logic wbWe, // wishbone write enable
  input wire logic [9:0] wbAdr, // byte address
  input wire logic [3:0] wbSel, // byte selects
  input wire logic [31:0] wbDatI, // write data
  output logic [31:0] wbDatO, // read data
  output logic wbAck, // acknowledge
  input wire logic polarityInverted, // pulse: inverted polarity seen
  input wire logic prbsByteBad, // pulse: errored PRBS byte
  input wire logic errCountMode, // error counter mode, 0 saturates
  input wire logic statusRead, // pulse: phy status register read
  output logic statusPolarity, // general_phy_status polarity bit
  output logic lowRxThreshold, // lower 10BASE-T threshold
  output logic [9:0] squelchMv, // squelch-on threshold in mV
  output logic linkPulseEnable, // transmit normal link pulses
  output logic jabberEnable, // jabber active in 10BASE-Te
  output logic [9:0] testPacketGapBytes, // gap between test packets
  output logic irq // level interrupt
);
  logic [15:0] ctrl_ff;
  logic pol_ff;
  logic [7:0] cnt_ff;
  logic [7:0] held_ff;
  logic [7:0] gap_ff;
  logic [pbr_pkg::IRQ_W-1:0] stat_ff;
  logic [pbr_pkg::IRQ_W-1:0] mask_ff;
  logic ack_ff;
  logic [31:0] dat_ff;
  logic req;
  logic wrLo;
  logic wrHi;
  logic rdCtrl;
  logic satHit;
  logic capWr;
  logic gapWr;

  // byte-lane write strobe for one register
  function automatic logic wrHit(input logic [9:0] adr, input logic [9:0] reg_adr,
                                 input logic sel);
    return (adr == reg_adr) && sel;
  endfunction

  // single new request, answered one cycle later
  assign req = wbCyc && wbStb && !ack_ff;
  assign wrLo = req && wbWe;
  assign wrHi = req && wbWe;
  assign rdCtrl = req && !wbWe && (wbAdr == pbr_pkg::ADDR_CTRL);
  // capture write on the high lane, gap write on the low lane
  assign capWr = wrHit(wbAdr, pbr_pkg::ADDR_TEST, wbSel[1]) && wrHi
                 && wbDatI[pbr_pkg::BIT_CAPTURE];
  assign gapWr = wrHit(wbAdr, pbr_pkg::ADDR_TEST, wbSel[0]) && wrLo;
  // a capture in the same cycle clears the count, so no saturation event
  assign satHit = prbsByteBad && !errCountMode && !capWr
                  && (cnt_ff == pbr_pkg::CNT_MAX - 8'h01);

  // ack strobe
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req;
    end
  end

  // control register, writable bits only
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_ff <= pbr_pkg::CTRL_RESET;
    end else begin
      if (wrHit(wbAdr, pbr_pkg::ADDR_CTRL, wbSel[0]) && wrLo) begin
        ctrl_ff[7:0] <= wbDatI[7:0] & pbr_pkg::CTRL_WMASK[7:0]; // see RULE_12
      end
      if (wrHit(wbAdr, pbr_pkg::ADDR_CTRL, wbSel[1]) && wrHi) begin
        ctrl_ff[15:8] <= wbDatI[15:8] & pbr_pkg::CTRL_WMASK[15:8]; // see RULE_12
      end
    end
  end

  // polarity flag, cleared by control read; new event wins
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pol_ff <= 1'b0;
    end else if (polarityInverted) begin
      pol_ff <= 1'b1;
    end else if (rdCtrl) begin
      pol_ff <= 1'b0; // see RULE_05
    end
  end

  // running errored-byte counter
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_ff <= 8'h00;
    end else if (capWr) begin
      cnt_ff <= {7'h00, prbsByteBad}; // see RULE_08
    end else if (prbsByteBad) begin
      if (errCountMode || cnt_ff != pbr_pkg::CNT_MAX) begin
        cnt_ff <= cnt_ff + 8'h01; // see RULE_07 RULE_09
      end
    end
  end

  // captured count and gap field
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      held_ff <= 8'h00;
      gap_ff <= pbr_pkg::GAP_RESET; // see RULE_11
    end else begin
      if (capWr) begin
        held_ff <= cnt_ff; // see RULE_08
      end
      if (gapWr) begin
        gap_ff <= wbDatI[7:0];
      end
    end
  end

  // interrupt status, write one to clear, set wins; mask written directly
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stat_ff <= '0;
      mask_ff <= '0;
    end else begin
      for (int i = 0; i < pbr_pkg::IRQ_W; i++) begin
        if ((i == pbr_pkg::IRQ_POL && polarityInverted) || (i == pbr_pkg::IRQ_SAT && satHit)) begin
          stat_ff[i] <= 1'b1;
        end else if (wrHit(wbAdr, pbr_pkg::ADDR_IRQ_STAT, wbSel[0]) && wrLo && wbDatI[i]) begin
          stat_ff[i] <= 1'b0;
        end
      end
      if (wrHit(wbAdr, pbr_pkg::ADDR_IRQ_MASK, wbSel[0]) && wrLo) begin
        mask_ff <= wbDatI[pbr_pkg::IRQ_W-1:0];
      end
    end
  end

  // read data register, unmapped reads zero
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dat_ff <= 32'h0000_0000;
    end else if (req && !wbWe) begin
      case (wbAdr)
        pbr_pkg::ADDR_CTRL: dat_ff <= {16'h0, ctrl_ff[15:5], pol_ff, ctrl_ff[3:0]}; // see RULE_04
        pbr_pkg::ADDR_TEST: dat_ff <= {16'h0000, held_ff, gap_ff};
        pbr_pkg::ADDR_IRQ_STAT: dat_ff <= {30'h0, stat_ff};
        pbr_pkg::ADDR_IRQ_MASK: dat_ff <= {30'h0, mask_ff};
        default: dat_ff <= 32'h0000_0000;
      endcase
    end
  end

  assign wbAck = ack_ff;
  assign wbDatO = dat_ff;
  // the status copy is never cleared by statusRead
  assign statusPolarity = pol_ff; // see RULE_04 RULE_05
  assign lowRxThreshold = ctrl_ff[pbr_pkg::BIT_LOW_THR]; // see RULE_01
  // codes above 8 are held at the top threshold
  assign squelchMv = (ctrl_ff[12:9] > pbr_pkg::SQ_MAX_CODE)
    ? pbr_pkg::SQ_BASE_MV + 10'(pbr_pkg::SQ_STEP_MV * 10'(pbr_pkg::SQ_MAX_CODE))
    : pbr_pkg::SQ_BASE_MV + 10'(pbr_pkg::SQ_STEP_MV * 10'(ctrl_ff[12:9])); // see RULE_02
  assign linkPulseEnable = !ctrl_ff[pbr_pkg::BIT_LINK_SUPP]; // see RULE_03
  assign jabberEnable = !ctrl_ff[pbr_pkg::BIT_JAB_DIS]; // see RULE_06
  assign testPacketGapBytes = {gap_ff, 2'b00}; // see RULE_10
  assign irq = |(stat_ff & mask_ff);

  // polarity event is visible next cycle, read clears it
  property p_pol_set;
    @(posedge clock) disable iff (!rst_n) polarityInverted |=> statusPolarity;
  endproperty
  a_pol_set: assert property (p_pol_set) else $error("polarity not latched"); // see RULE_04

  property p_pol_clear;
    @(posedge clock) disable iff (!rst_n)
      rdCtrl && !polarityInverted |=> !statusPolarity;
  endproperty
  a_pol_clear: assert property (p_pol_clear) else $error("read left polarity"); // see RULE_05

  property p_stat_read;
    @(posedge clock) disable iff (!rst_n)
      statusRead && !rdCtrl && statusPolarity |=> statusPolarity;
  endproperty
  a_stat_read: assert property (p_stat_read) else $error("status read cleared"); // see RULE_05

  property p_saturate;
    @(posedge clock) disable iff (!rst_n)
      !errCountMode && cnt_ff == 8'hFF && !(req && wbWe) |=> cnt_ff == 8'hFF;
  endproperty
  a_saturate: assert property (p_saturate) else $error("counter wrapped"); // see RULE_09

  property p_count;
    @(posedge clock) disable iff (!rst_n)
      prbsByteBad && cnt_ff < 8'hFE && !(req && wbWe) |=> cnt_ff == $past(cnt_ff) + 8'h01;
  endproperty
  a_count: assert property (p_count) else $error("errored byte not counted"); // see RULE_07

  property p_capture;
    @(posedge clock) disable iff (!rst_n)
      wrHi && wbAdr == pbr_pkg::ADDR_TEST && wbSel[1] && wbDatI[15]
      |=> held_ff == $past(cnt_ff) && cnt_ff <= 8'h01;
  endproperty
  a_capture: assert property (p_capture) else $error("capture failed"); // see RULE_08

  property p_gap;
    @(posedge clock) disable iff (!rst_n) testPacketGapBytes == 10'(gap_ff) * 10'h004;
  endproperty
  a_gap: assert property (p_gap) else $error("gap not four times field"); // see RULE_10

  property p_gap_reset;
    @(posedge clock) !rst_n |=> gap_ff == 8'h7D && ctrl_ff == 16'h0000;
  endproperty
  a_gap_reset: assert property (p_gap_reset) else $error("bad reset values"); // see RULE_11

  property p_reserved;
    @(posedge clock) disable iff (!rst_n) (ctrl_ff & ~16'h3E81) == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit stored"); // see RULE_12

  property p_ctrl_out;
    @(posedge clock) disable iff (!rst_n)
      linkPulseEnable == !ctrl_ff[7] && jabberEnable == !ctrl_ff[0]
      && lowRxThreshold == ctrl_ff[13];
  endproperty
  a_ctrl_out: assert property (p_ctrl_out) else $error("ctrl out"); // see RULE_01 RULE_03 RULE_06

  property p_squelch;
    @(posedge clock) disable iff (!rst_n)
      ctrl_ff[12:9] == 4'h0 |-> squelchMv == 10'h0C8;
  endproperty
  a_squelch: assert property (p_squelch) else $error("squelch base wrong"); // see RULE_02

  property p_squelch_top;
    @(posedge clock) disable iff (!rst_n)
      ctrl_ff[12:9] >= pbr_pkg::SQ_MAX_CODE |-> squelchMv == 10'h258;
  endproperty
  a_squelch_top: assert property (p_squelch_top) else $error("squelch top wrong"); // see RULE_02

  property p_squelch_mid;
    @(posedge clock) disable iff (!rst_n)
      ctrl_ff[12:9] == 4'h4 |-> squelchMv == 10'h190;
  endproperty
  a_squelch_mid: assert property (p_squelch_mid) else $error("squelch step wrong"); // see RULE_02

  // wrap mode rolls over instead of sticking at the top
  property p_wrap;
    @(posedge clock) disable iff (!rst_n)
      errCountMode && prbsByteBad && cnt_ff == 8'hFF && !capWr |=> cnt_ff == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap"); // see RULE_09

  property p_sat_flag;
    @(posedge clock) disable iff (!rst_n) satHit |=> stat_ff[pbr_pkg::IRQ_SAT];
  endproperty
  a_sat_flag: assert property (p_sat_flag) else $error("saturation not flagged"); // see RULE_09

  // captured count only moves on a capture write
  property p_held;
    @(posedge clock) disable iff (!rst_n) !capWr |=> $stable(held_ff);
  endproperty
  a_held: assert property (p_held) else $error("captured count moved"); // see RULE_08

  property p_gap_write;
    @(posedge clock) disable iff (!rst_n) gapWr |=> gap_ff == $past(wbDatI[7:0]);
  endproperty
  a_gap_write: assert property (p_gap_write) else $error("gap write lost"); // see RULE_10

  // read data shows the registers as they stood when the read was taken
  property p_pol_read;
    @(posedge clock) disable iff (!rst_n)
      rdCtrl |=> wbDatO[pbr_pkg::BIT_POL] == $past(pol_ff);
  endproperty
  a_pol_read: assert property (p_pol_read) else $error("polarity bit not read"); // see RULE_04

  property p_ctrl_read;
    @(posedge clock) disable iff (!rst_n)
      rdCtrl |=> wbDatO[31:14] == 18'h00000 && wbDatO[8] == 1'b0 && wbDatO[6:5] == 2'h0
      && wbDatO[3:1] == 3'h0;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("reserved bit read high"); // see RULE_12

  property p_test_read;
    @(posedge clock) disable iff (!rst_n)
      req && !wbWe && wbAdr == pbr_pkg::ADDR_TEST
      |=> wbDatO == {16'h0000, $past(held_ff), $past(gap_ff)};
  endproperty
  a_test_read: assert property (p_test_read) else $error("self-test read wrong"); // see RULE_07

  // bus handshake: one ack per taken request, read data held between reads
  property p_ack_resp;
    @(posedge clock) disable iff (!rst_n) req |=> wbAck;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("request not acknowledged");

  property p_ack_pulse;
    @(posedge clock) disable iff (!rst_n) wbAck |=> !wbAck;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

  property p_dat_hold;
    @(posedge clock) disable iff (!rst_n) !(req && !wbWe) |=> $stable(wbDatO);
  endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data changed without read");
endmodule

// ==== testbench/phy_10bt_and_selftest_regs_bench.sv ====
// self-checking bench for the 10BASE-T control and self-test register bank
`timescale 1ns/100ps
module phy_10bt_and_selftest_regs_bench;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic [9:0] wbAdr = 10'h000;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatI = 32'h0, wbDatO, q;
  logic wbAck, statusPolarity, lowRxThreshold, linkPulseEnable, jabberEnable, irq;
  logic polarityInverted = 1'b0, prbsByteBad = 1'b0, errCountMode = 1'b0, statusRead = 1'b0;
  logic [9:0] squelchMv, testPacketGapBytes;
  logic [15:0] r;
  int error_cnt = 0, checks = 0, cycles = 0, i, n;
  int seed = 32'hC834;

  pbr_regs DUT (.clock(clock), .rst_n(rst_n), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck),
    .polarityInverted(polarityInverted), .prbsByteBad(prbsByteBad),
    .errCountMode(errCountMode), .statusRead(statusRead), .statusPolarity(statusPolarity),
    .lowRxThreshold(lowRxThreshold), .squelchMv(squelchMv), .linkPulseEnable(linkPulseEnable),
    .jabberEnable(jabberEnable), .testPacketGapBytes(testPacketGapBytes), .irq(irq));

  // 250 MHz clock
  initial forever #2 clock = ~clock;

  // expected squelch threshold, codes above 8 clamp
  function automatic logic [9:0] sq(input logic [3:0] c);
    return (c > 4'h8) ? 10'h258 : 10'h0C8 + 10'h032 * c;
  endfunction

  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one classic wishbone cycle, waits for ack
  task automatic wb(input logic we, input logic [9:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] rd);
    @(posedge clock);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatI <= d;
    wbSel <= s;
    do @(posedge clock); while (wbAck !== 1'b1);
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask

  // errored bytes for k sampling edges, then capture and read back
  task automatic bad_bytes(input int k, output logic [31:0] rd);
    if (k > 0) begin
      @(posedge clock) prbsByteBad <= 1'b1;
      repeat (k) @(posedge clock);
      prbsByteBad <= 1'b0;
    end
    wb(1'b1, pbr_pkg::ADDR_TEST, 32'h8000, 4'h2, rd);
    wb(1'b0, pbr_pkg::ADDR_TEST, 32'h0, 4'h3, rd);
  endtask

  // verdict and end of run
  task automatic test_done;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      test_done;
    end
  end

  // main sequence
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    chk("gapBytes", testPacketGapBytes, 32'h1F4);
    wb(1'b0, pbr_pkg::ADDR_CTRL, 32'h0, 4'h3, q);
    chk("ctrlReset", q, 32'h0);
    wb(1'b0, pbr_pkg::ADDR_TEST, 32'h0, 4'h3, q);
    chk("testReset", q, 32'h7D);
    // control fields, corners then random
    for (i = 0; i < 12; i++) begin
      r = 16'($random(seed));
      if (i < 2) r = i ? 16'hFFFF : 16'h1000;
      wb(1'b1, pbr_pkg::ADDR_CTRL, {16'h0, r}, 4'h3, q);
      wb(1'b0, pbr_pkg::ADDR_CTRL, 32'h0, 4'h3, q);
      chk("ctrl", q, {16'h0, r & pbr_pkg::CTRL_WMASK});
      chk("lowThr", lowRxThreshold, r[13]);
      chk("squelch", squelchMv, sq(r[12:9]));
      chk("linkPulse", linkPulseEnable, !r[7]);
      chk("jabber", jabberEnable, !r[0]);
    end
    // polarity event, status read keeps it, control read clears it
    @(posedge clock) polarityInverted <= 1'b1;
    @(posedge clock) polarityInverted <= 1'b0;
    statusRead <= 1'b1;
    @(posedge clock) statusRead <= 1'b0;
    repeat (2) @(posedge clock);
    chk("statPol", statusPolarity, 1'b1);
    chk("irqMasked", irq, 1'b0);
    wb(1'b0, pbr_pkg::ADDR_CTRL, 32'h0, 4'h3, q);
    chk("ctrlPol", q[4], 1'b1);
    chk("statPolClr", statusPolarity, 1'b0);
    wb(1'b0, pbr_pkg::ADDR_CTRL, 32'h0, 4'h3, q);
    chk("ctrlPolClr", q[4], 1'b0);
    wb(1'b0, pbr_pkg::ADDR_IRQ_STAT, 32'h0, 4'h3, q);
    chk("irqStat", q[1:0], 2'h1);
    wb(1'b1, pbr_pkg::ADDR_IRQ_STAT, 32'h3, 4'h3, q);
    // errored byte count, capture clears the running count
    errCountMode <= 1'b1;
    n = 1 + ($random(seed) & 63);
    bad_bytes(n, q);
    chk("count", q, {16'h0, n[7:0], 8'h7D});
    bad_bytes(0, q);
    chk("countClr", q, 32'h7D);
    bad_bytes(258, q);
    chk("countWrap", q, 32'h027D);
    // saturation with its interrupt unmasked
    errCountMode <= 1'b0;
    wb(1'b1, pbr_pkg::ADDR_IRQ_MASK, 32'h2, 4'h3, q);
    bad_bytes(300, q);
    chk("countSat", q, 32'hFF7D);
    chk("irqSat", irq, 1'b1);
    wb(1'b1, pbr_pkg::ADDR_IRQ_STAT, 32'h2, 4'h3, q);
    chk("irqClr", irq, 1'b0);
    // packet gap field
    r = 16'($random(seed));
    wb(1'b1, pbr_pkg::ADDR_TEST, {24'h0, r[7:0]}, 4'h1, q);
    chk("gapField", testPacketGapBytes, {22'h0, r[7:0], 2'h0});
    wb(1'b0, 10'h3FC, 32'h0, 4'h3, q);
    chk("unmapped", q, 32'h0);
    test_done;
  end
endmodule
